/* File: shared/erc_consts.svh */
/*
 * Offsets, field positions and reset values of the third-rail
 * configuration controller.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef ERC_CONSTS_SVH
`define ERC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ERC_OFF_MODE_CTRL 5'h00
`define ERC_OFF_HARDWARE_CONTROL_REG 5'h04
`define ERC_OFF_SUP_STAT 5'h08
`define ERC_OFF_RAIL_STATE 5'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ERC_BIT_RAIL3_EN 0
`define ERC_BIT_VSEL 1
`define ERC_BIT_KEEP_UV 2
`define ERC_BIT_KEEP_STOP 3
`define ERC_BIT_LS_EN 0
`define ERC_BIT_OC_FLAG 0
`define ERC_BIT_UV_FLAG 1
`define ERC_BIT_FAIL_FLAG 2
`define ERC_BIT_ST_ALONE 0
`define ERC_BIT_ST_SHARE 1
`define ERC_BIT_ST_ON 2
`define ERC_BIT_ST_HP 3
`define ERC_BIT_ST_LP 4
`define ERC_BIT_ST_SUP_UV 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ERC_RST_MODE_CTRL 4'h0
`define ERC_RST_LS 1'b0
`define ERC_RST_FLAGS 3'h0
`define ERC_RST_PIN 1'b0

`endif

/* File: shared/erc_pkg.sv */
/*
 * Types of the third-rail configuration controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package erc_pkg;

  // --------------------------------------------------------------------
  // System operating mode, given by the system controller
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ERC_MODE_INIT = 3'h0,
    ERC_MODE_NORMAL = 3'h1,
    ERC_MODE_STOP = 3'h2,
    ERC_MODE_SLEEP = 3'h3,
    ERC_MODE_RESTART = 3'h4,
    ERC_MODE_FAILSAFE = 3'h5
  } erc_sys_mode_t;

  // --------------------------------------------------------------------
  // Rail configuration, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ERC_CFG_NONE = 3'h1,
    ERC_CFG_ALONE = 3'h2,
    ERC_CFG_SHARE = 3'h4
  } erc_cfg_t;

  // Pin inputs, in the order the synchroniser carries them
  typedef struct packed {
    logic supply_undervoltage;
    logic shunt_threshold;
    logic rail_undervoltage;
    logic base_above_upper;
    logic base_below_lower;
  } erc_pins_t;

endpackage : erc_pkg

/* File: shared/erc_pin_if.sv */
/*
 * Carries raw pin levels into the synchroniser and clean levels out.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface erc_pin_if;
  erc_pkg::erc_pins_t raw;
  erc_pkg::erc_pins_t clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : erc_pin_if

/* File: verilog/erc_pin_sync.sv */
/*
 * Three-flop synchroniser with agreement filter for the pin inputs.
 * Assumes the pins are asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
`include "erc_consts.svh"
module erc_pin_sync (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  erc_pin_if.sync pins
);

  typedef struct packed {
    erc_pkg::erc_pins_t s1;
    erc_pkg::erc_pins_t s2;
    erc_pkg::erc_pins_t s3;
    erc_pkg::erc_pins_t clean;
  } erc_sync_state_t;

  erc_sync_state_t st;
  erc_sync_state_t next_st;

  // --------------------------------------------------------------------
  // Shift chain; a level counts only once stages two and three agree,
  // so the first stage is seen by the second stage alone
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pins.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < $bits(erc_pkg::erc_pins_t); i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.clean[i] = st.s3[i];
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= {4 * $bits(erc_pkg::erc_pins_t){`ERC_RST_PIN}};
    end else begin
      st <= next_st;
    end
  end

  assign pins.clean = st.clean;

endmodule : erc_pin_sync

/* File: verilog/erc_ctrl.sv */
/*
 * Third-rail configuration and mode controller for an external pass
 * transistor regulator, with an Avalon-MM register slave.
 * Assumes: rst_b_i is the power-on reset (it alone clears the locked
 * configuration); soft_reset_i and sys_mode_i come from logic on
 * clk_sys_i; the comparator pins are asynchronous.
 */
`timescale 1ns/1ps
`include "erc_consts.svh"

// Contract
// - Stand-alone: select bit clear gives 5.0 V, set gives 3.3 V.
// - Load-sharing ignores the output voltage select bit.
// - Rail enable written in Normal mode selects stand-alone.
// - Setting the load-sharing bit selects load-sharing.
// - First enable or load-sharing set locks config until power-off.
// - Stand-alone: off in Init/Fail-Safe, switchable in Normal, else held.
// - Load-sharing follows main rail: off Init/Sleep/Fail-Safe, on Restart.
// - Stop without keep bit turns sharing off, bit stays, resumes Normal.
// - Load-sharing with Stop-keep-on bit keeps rail on in Stop.
// - Stop: high-power regulator on above upper, off below lower peak.
// - Normal mode runs only the high-power regulator.
// - Supply undervoltage turns rail off and back on, unless keep-on.
// - Locked stand-alone: rail switchable, change ignored, no fail flag.
// - Locked load-sharing: change attempt sets fail flag, no change.
// - Load-sharing: rail enable bit has no function.
// - Stand-alone shunt threshold limits and sets overcurrent flag only.
// - Stand-alone rail undervoltage sets the undervoltage flag.
// - Load-sharing: no undervoltage report; off in Fail-Safe.
// - Load-sharing never raises the overcurrent flag.
module erc_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic soft_reset_i,
  input wire erc_pkg::erc_sys_mode_t sys_mode_i,
  input wire logic supply_undervoltage_i,
  input wire logic shunt_threshold_i,
  input wire logic rail_undervoltage_i,
  input wire logic base_above_upper_i,
  input wire logic base_below_lower_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic rail3_drive_en_o,
  output logic rail3_voltage_3v3_o,
  output logic current_limit_en_o,
  output logic hp_regulator_en_o,
  output logic lp_regulator_en_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    erc_pkg::erc_cfg_t cfg;
    logic rail3_enable;
    logic rail3_voltage_select;
    logic rail3_keep_on_supply_uv;
    logic rail3_share_keep_in_stop;
    logic rail3_load_share_enable;
    logic rail3_overcurrent_flag;
    logic rail3_undervoltage_flag;
    logic serial_fail_flag;
    logic hp_stop;
    logic ack;
    logic [31:0] rdata;
    logic rail_on;
    logic hp_en;
    logic lp_en;
    logic vsel_out;
    logic limit_en;
  } erc_state_t;

  erc_state_t st;
  erc_state_t next_st;

  erc_pin_if pin_bus ();

  logic req;
  logic wr_go;
  logic lane0;
  logic wr_mode_ctrl;
  logic wr_hardware_control_reg;
  logic wr_sup_stat;
  logic want_alone;
  logic want_share;
  logic is_alone;
  logic is_share;
  logic sup_uv;
  logic uv_cut;
  logic rail_on;
  logic [31:0] rd_mux;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  assign pin_bus.raw.supply_undervoltage = supply_undervoltage_i;
  assign pin_bus.raw.shunt_threshold = shunt_threshold_i;
  assign pin_bus.raw.rail_undervoltage = rail_undervoltage_i;
  assign pin_bus.raw.base_above_upper = base_above_upper_i;
  assign pin_bus.raw.base_below_lower = base_below_lower_i;

  erc_pin_sync u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pins(pin_bus.sync)
  );

  // --------------------------------------------------------------------
  // Bus decode: every access waits one cycle, so the read data is a
  // flop and the write lands on the edge that releases the master
  // --------------------------------------------------------------------
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~st.ack;
  assign wr_go = avs_write_i & st.ack;
  assign lane0 = avs_byteenable_i[0];
  assign wr_mode_ctrl = wr_go & lane0
                      & (avs_address_i == `ERC_OFF_MODE_CTRL);
  assign wr_hardware_control_reg = wr_go & lane0 & (avs_address_i == `ERC_OFF_HARDWARE_CONTROL_REG);
  assign wr_sup_stat = wr_go & lane0
                     & (avs_address_i == `ERC_OFF_SUP_STAT);

  // Configuration requests carried by this write
  assign want_alone = wr_mode_ctrl
                    & avs_writedata_i[`ERC_BIT_RAIL3_EN]
                    & (sys_mode_i == erc_pkg::ERC_MODE_NORMAL);
  assign want_share = wr_hardware_control_reg & avs_writedata_i[`ERC_BIT_LS_EN];

  assign is_alone = (st.cfg == erc_pkg::ERC_CFG_ALONE);
  assign is_share = (st.cfg == erc_pkg::ERC_CFG_SHARE);

  // --------------------------------------------------------------------
  // Rail on/off by mode and configuration
  // --------------------------------------------------------------------
  assign sup_uv = pin_bus.clean.supply_undervoltage;
  assign uv_cut = sup_uv & ~st.rail3_keep_on_supply_uv;

  always_comb begin
    rail_on = 1'b0;
    if (is_alone) begin
      unique case (sys_mode_i)
        erc_pkg::ERC_MODE_INIT,
        erc_pkg::ERC_MODE_FAILSAFE: rail_on = 1'b0;
        // Outside Normal only soft reset changes the bit, so the rail holds its state
        default: rail_on = st.rail3_enable;
      endcase
    end else if (is_share) begin
      // Enable bit is not looked at here
      unique case (sys_mode_i)
        erc_pkg::ERC_MODE_NORMAL: rail_on = st.rail3_load_share_enable;
        erc_pkg::ERC_MODE_RESTART: rail_on = 1'b1;
        erc_pkg::ERC_MODE_STOP: begin
          rail_on = st.rail3_share_keep_in_stop;
        end
        default: rail_on = 1'b0;
      endcase
    end
    if (uv_cut) begin
      rail_on = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read mux; reserved bits and unmapped offsets read as zero
  // --------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      `ERC_OFF_MODE_CTRL: begin
        rd_mux[`ERC_BIT_RAIL3_EN] = st.rail3_enable;
        rd_mux[`ERC_BIT_VSEL] = st.rail3_voltage_select;
        rd_mux[`ERC_BIT_KEEP_UV] = st.rail3_keep_on_supply_uv;
        rd_mux[`ERC_BIT_KEEP_STOP] = st.rail3_share_keep_in_stop;
      end
      `ERC_OFF_HARDWARE_CONTROL_REG: begin
        rd_mux[`ERC_BIT_LS_EN] = st.rail3_load_share_enable;
      end
      `ERC_OFF_SUP_STAT: begin
        rd_mux[`ERC_BIT_OC_FLAG] = st.rail3_overcurrent_flag;
        rd_mux[`ERC_BIT_UV_FLAG] = st.rail3_undervoltage_flag;
        rd_mux[`ERC_BIT_FAIL_FLAG] = st.serial_fail_flag;
      end
      `ERC_OFF_RAIL_STATE: begin
        rd_mux[`ERC_BIT_ST_ALONE] = is_alone;
        rd_mux[`ERC_BIT_ST_SHARE] = is_share;
        rd_mux[`ERC_BIT_ST_ON] = st.rail_on;
        rd_mux[`ERC_BIT_ST_HP] = st.hp_en;
        rd_mux[`ERC_BIT_ST_LP] = st.lp_en;
        rd_mux[`ERC_BIT_ST_SUP_UV] = sup_uv;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      next_st.rdata = rd_mux;
    end

    // Control bits; a write moves the enable bit only in Normal mode
    if (wr_mode_ctrl) begin
      if (sys_mode_i == erc_pkg::ERC_MODE_NORMAL) begin
        next_st.rail3_enable = avs_writedata_i[`ERC_BIT_RAIL3_EN];
      end
      next_st.rail3_voltage_select = avs_writedata_i[`ERC_BIT_VSEL];
      next_st.rail3_keep_on_supply_uv = avs_writedata_i[`ERC_BIT_KEEP_UV];
      next_st.rail3_share_keep_in_stop = avs_writedata_i[`ERC_BIT_KEEP_STOP];
    end

    // Configuration choice and lock; sharing wins a tie because the
    // enable bit has no meaning once sharing is chosen
    unique case (st.cfg)
      erc_pkg::ERC_CFG_NONE: begin
        if (want_share) begin
          next_st.cfg = erc_pkg::ERC_CFG_SHARE;
          next_st.rail3_load_share_enable = 1'b1;
        end else if (want_alone) begin
          next_st.cfg = erc_pkg::ERC_CFG_ALONE;
        end
      end
      erc_pkg::ERC_CFG_ALONE: begin
        // Sharing requests are dropped silently
      end
      erc_pkg::ERC_CFG_SHARE: begin
        // Clearing the sharing bit or asking for stand-alone is refused
        if ((wr_hardware_control_reg & ~avs_writedata_i[`ERC_BIT_LS_EN]) |
            want_alone) begin
          next_st.serial_fail_flag = 1'b1;
        end
      end
      default: next_st.cfg = erc_pkg::ERC_CFG_NONE;
    endcase

    // Flags: write one to clear, a same-cycle event wins
    if (wr_sup_stat) begin
      if (avs_writedata_i[`ERC_BIT_OC_FLAG]) begin
        next_st.rail3_overcurrent_flag = 1'b0;
      end
      if (avs_writedata_i[`ERC_BIT_UV_FLAG]) begin
        next_st.rail3_undervoltage_flag = 1'b0;
      end
      if (avs_writedata_i[`ERC_BIT_FAIL_FLAG]) begin
        next_st.serial_fail_flag = 1'b0;
      end
      if (st.cfg == erc_pkg::ERC_CFG_SHARE &&
          ((wr_hardware_control_reg & ~avs_writedata_i[`ERC_BIT_LS_EN]) | want_alone)) begin
        next_st.serial_fail_flag = 1'b1;
      end
    end
    // Only stand-alone has a current limit or undervoltage report
    if (is_alone & st.rail_on & pin_bus.clean.shunt_threshold) begin
      next_st.rail3_overcurrent_flag = 1'b1;
    end
    if (is_alone & st.rail_on & pin_bus.clean.rail_undervoltage) begin
      next_st.rail3_undervoltage_flag = 1'b1;
    end

    // Stop-mode regulator hand-over with hysteresis
    if (sys_mode_i != erc_pkg::ERC_MODE_STOP || !rail_on) begin
      next_st.hp_stop = 1'b0;
    end else if (pin_bus.clean.base_above_upper) begin
      next_st.hp_stop = 1'b1;
    end else if (pin_bus.clean.base_below_lower) begin
      next_st.hp_stop = 1'b0;
    end

    // Registered outputs
    next_st.rail_on = rail_on;
    next_st.lp_en = rail_on
                  & (sys_mode_i != erc_pkg::ERC_MODE_NORMAL);
    if (sys_mode_i == erc_pkg::ERC_MODE_STOP) begin
      next_st.hp_en = rail_on & next_st.hp_stop;
    end else begin
      next_st.hp_en = rail_on
                    & (sys_mode_i == erc_pkg::ERC_MODE_NORMAL);
    end
    next_st.vsel_out = is_alone & st.rail3_voltage_select;
    next_st.limit_en = is_alone & rail_on;

    // Soft reset clears the software view but keeps the lock; the
    // sharing bit stays with its locked configuration
    if (soft_reset_i) begin
      next_st.rail3_enable = 1'b0;
      next_st.rail3_voltage_select = 1'b0;
      next_st.rail3_keep_on_supply_uv = 1'b0;
      next_st.rail3_share_keep_in_stop = 1'b0;
      next_st.rail3_overcurrent_flag = 1'b0;
      next_st.rail3_undervoltage_flag = 1'b0;
      next_st.serial_fail_flag = 1'b0;
      next_st.cfg = st.cfg;
    end
  end

  // --------------------------------------------------------------------
  // Register stage; power-on reset is the only way out of a lock
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.cfg <= erc_pkg::ERC_CFG_NONE;
      {st.rail3_share_keep_in_stop, st.rail3_keep_on_supply_uv,
       st.rail3_voltage_select, st.rail3_enable} <= `ERC_RST_MODE_CTRL;
      st.rail3_load_share_enable <= `ERC_RST_LS;
      {st.serial_fail_flag, st.rail3_undervoltage_flag,
       st.rail3_overcurrent_flag} <= `ERC_RST_FLAGS;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign avs_readdata_o = st.rdata;
  assign rail3_drive_en_o = st.rail_on;
  assign rail3_voltage_3v3_o = st.vsel_out;
  assign current_limit_en_o = st.limit_en;
  assign hp_regulator_en_o = st.hp_en;
  assign lp_regulator_en_o = st.lp_en;

endmodule : erc_ctrl

/* File: verification/erc_ctrl_assertions.sv */
/*
 * Port-level checker of the third-rail controller.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module erc_ctrl_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire erc_pkg::erc_sys_mode_t sys_mode_i,
  input wire logic base_above_upper_i,
  input wire logic base_below_lower_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic rail3_drive_en_o,
  input wire logic current_limit_en_o,
  input wire logic hp_regulator_en_o,
  input wire logic lp_regulator_en_o
);
  // ----------------------------------------------------------------
  // Clocking and named sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // Seven cycles covers the pin filter and the output register
  sequence above_held;
    (sys_mode_i == erc_pkg::ERC_MODE_STOP && rail3_drive_en_o &&
      base_above_upper_i)[*7];
  endsequence
  sequence below_held;
    (sys_mode_i == erc_pkg::ERC_MODE_STOP && rail3_drive_en_o &&
      base_below_lower_i && !base_above_upper_i)[*7];
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  hp_stop_on_a: assert property (
    above_held |=> hp_regulator_en_o) else $error("hp not raised in stop");
  hp_stop_off_a: assert property (
    below_held |=> !hp_regulator_en_o) else $error("hp not dropped");
  lp_stop_a: assert property (
    (sys_mode_i == erc_pkg::ERC_MODE_STOP && rail3_drive_en_o)[*3] ##1
    rail3_drive_en_o |-> lp_regulator_en_o) else $error("lp off in stop");
  normal_no_lp_a: assert property (
    sys_mode_i == erc_pkg::ERC_MODE_NORMAL |=> !lp_regulator_en_o)
    else $error("lp on in normal");
  init_off_a: assert property (
    sys_mode_i == erc_pkg::ERC_MODE_INIT |=> !rail3_drive_en_o)
    else $error("rail on in init");
  failsafe_off_a: assert property (
    sys_mode_i == erc_pkg::ERC_MODE_FAILSAFE |=> !rail3_drive_en_o)
    else $error("rail on in fail-safe");
  limit_drop_a: assert property (
    $fell(rail3_drive_en_o) |-> !current_limit_en_o)
    else $error("limit kept with rail off");
  wait_first_a: assert property (
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait cycle");
  wait_one_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait longer than one cycle");
  unmapped_zero_a: assert property (
    avs_read_i && !avs_waitrequest_o &&
    (avs_address_i > 5'h0c || avs_address_i[1:0] != 2'h0) |->
    avs_readdata_o == 32'h0) else $error("unmapped read not zero");
endmodule : erc_ctrl_assertions

/* File: verification/erc_pass_model.sv */
/*
 * Behavioural pass transistor, shunt and rail comparators.
 * Assumes the bench commands load and droop levels.
 */
`timescale 1ns/1ps
module erc_pass_model (
  input wire logic drive_en_i,
  input wire logic [1:0] load_i,
  input wire logic droop_i,
  output logic shunt_threshold_o,
  output logic rail_undervoltage_o,
  output logic base_above_upper_o,
  output logic base_below_lower_o
);
  // Load 3 reaches the shunt threshold whatever the configuration
  assign shunt_threshold_o = drive_en_i && load_i == 2'h3;
  // Comparator is armed only while the base is driven; a rail that is
  // just switching on must not look like a droop behind the pin filter
  assign rail_undervoltage_o = droop_i && drive_en_i;
  // Base current tracks load only while the base is driven
  assign base_above_upper_o = drive_en_i && load_i >= 2'h2;
  assign base_below_lower_o = !drive_en_i || load_i == 2'h0;
endmodule : erc_pass_model

/* File: verification/ext_regulator_config_ctrl_tb_top.sv */
/*
 * Self-checking bench of the third-rail controller with pass model.
 * Assumes package, interface and design files compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) check_eq(32'(g), 32'(e))
module ext_regulator_config_ctrl_tb_top;
  logic clk, rst_b, soft_rst, sup_uv, droop, av_rd, av_wr, av_wait;
  logic drive, v3v3, limit, hp, lp, shunt, rail_uv, above, below;
  logic [1:0] load;
  logic [4:0] av_addr;
  logic [31:0] av_wdata, av_rdata, q;
  erc_pkg::erc_sys_mode_t mode;
  int n_fail = 0;
  int checks = 0;

  erc_ctrl dut (.clk_sys_i(clk), .rst_b_i(rst_b), .soft_reset_i(soft_rst),
    .sys_mode_i(mode), .supply_undervoltage_i(sup_uv),
    .shunt_threshold_i(shunt), .rail_undervoltage_i(rail_uv),
    .base_above_upper_i(above), .base_below_lower_i(below),
    .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_writedata_i(av_wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
    .rail3_drive_en_o(drive), .rail3_voltage_3v3_o(v3v3),
    .current_limit_en_o(limit), .hp_regulator_en_o(hp),
    .lp_regulator_en_o(lp));
  erc_pass_model pass (.drive_en_i(drive), .load_i(load), .droop_i(droop),
    .shunt_threshold_o(shunt), .rail_undervoltage_o(rail_uv),
    .base_above_upper_o(above), .base_below_lower_o(below));

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_eq

  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    logic wt = 1'b1;
    av_addr <= a;
    av_wdata <= d;
    av_wr <= w;
    av_rd <= !w;
    while (wt === 1'b1 && n < 20) begin
      @(posedge clk);
      wt = av_wait;
      r = av_rdata;
      n++;
    end
    `CHK(wt, 0);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  // Pin filter plus output register needs up to five cycles
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic mode_chk(input erc_pkg::erc_sys_mode_t m, input logic e);
    mode <= m;
    settle();
    `CHK(drive, e);
  endtask : mode_chk

  task automatic power_on();
    rst_b <= 1'b0;
    mode <= erc_pkg::ERC_MODE_INIT;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : power_on

  task automatic pulse_soft();
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    settle();
  endtask : pulse_soft

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped place, enable refused outside Normal
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0, q);
      `CHK(q, 0);
    end
    wr(5'h14, 32'hf);
    wr(5'h00, 32'h1);
    bus(1'b0, 5'h0c, 32'h0, q);
    `CHK(q, 0);
  endtask : t_regs

  task automatic t_alone();
    mode <= erc_pkg::ERC_MODE_NORMAL;
    wr(5'h00, 32'h3);
    settle();
    bus(1'b0, 5'h0c, 32'h0, q);
    `CHK(q[2:0], 3'h5);
    `CHK({drive, v3v3, hp, lp}, 4'he);
    wr(5'h00, 32'h1);
    settle();
    `CHK(v3v3, 0);
    wr(5'h04, 32'h1);
    bus(1'b0, 5'h04, 32'h0, q);
    `CHK(q, 0);
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q, 0);
    load <= 2'h3;
    settle();
    `CHK(limit, 1);
    load <= 2'h1;
    settle();
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q[0], 1);
    wr(5'h08, 32'h1);
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q[0], 0);
    droop <= 1'b1;
    settle();
    droop <= 1'b0;
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q[1:0], 2'h2);
    sup_uv <= 1'b1;
    settle();
    `CHK(drive, 0);
    sup_uv <= 1'b0;
    settle();
    `CHK(drive, 1);
    wr(5'h00, 32'h5);
    sup_uv <= 1'b1;
    settle();
    `CHK(drive, 1);
    sup_uv <= 1'b0;
    mode_chk(erc_pkg::ERC_MODE_STOP, 1'b1);
    load <= 2'h2;
    settle();
    `CHK({hp, lp}, 2'h3);
    load <= 2'h1;
    settle();
    `CHK(hp, 1);
    load <= 2'h0;
    settle();
    `CHK({hp, lp}, 2'h1);
    mode_chk(erc_pkg::ERC_MODE_SLEEP, 1'b1);
    mode_chk(erc_pkg::ERC_MODE_RESTART, 1'b1);
    mode_chk(erc_pkg::ERC_MODE_FAILSAFE, 1'b0);
    mode_chk(erc_pkg::ERC_MODE_INIT, 1'b0);
    mode_chk(erc_pkg::ERC_MODE_NORMAL, 1'b1);
    wr(5'h00, 32'h0);
    settle();
    `CHK(drive, 0);
    pulse_soft();
    bus(1'b0, 5'h0c, 32'h0, q);
    `CHK(q[1:0], 2'h1);
    wr(5'h00, 32'h1);
    settle();
    `CHK(drive, 1);
  endtask : t_alone

  task automatic t_share();
    mode <= erc_pkg::ERC_MODE_NORMAL;
    wr(5'h00, 32'h2);
    wr(5'h04, 32'h1);
    settle();
    bus(1'b0, 5'h0c, 32'h0, q);
    `CHK(q[2:0], 3'h6);
    `CHK({drive, v3v3}, 2'h2);
    wr(5'h00, 32'h3);
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q[2], 1);
    wr(5'h08, 32'h4);
    wr(5'h04, 32'h0);
    bus(1'b0, 5'h04, 32'h0, q);
    `CHK(q[0], 1);
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q[2], 1);
    load <= 2'h3;
    droop <= 1'b1;
    settle();
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK({q[1:0], limit}, 3'h0);
    load <= 2'h1;
    droop <= 1'b0;
    mode_chk(erc_pkg::ERC_MODE_STOP, 1'b0);
    bus(1'b0, 5'h04, 32'h0, q);
    `CHK(q[0], 1);
    mode_chk(erc_pkg::ERC_MODE_NORMAL, 1'b1);
    wr(5'h00, 32'h8);
    mode_chk(erc_pkg::ERC_MODE_STOP, 1'b1);
    mode_chk(erc_pkg::ERC_MODE_SLEEP, 1'b0);
    mode_chk(erc_pkg::ERC_MODE_RESTART, 1'b1);
    mode_chk(erc_pkg::ERC_MODE_FAILSAFE, 1'b0);
    mode_chk(erc_pkg::ERC_MODE_INIT, 1'b0);
    mode <= erc_pkg::ERC_MODE_NORMAL;
    pulse_soft();
    bus(1'b0, 5'h0c, 32'h0, q);
    `CHK(q[1:0], 2'h2);
  endtask : t_share

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    soft_rst = 1'b0;
    sup_uv = 1'b0;
    droop = 1'b0;
    load = 2'h1;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = 5'h00;
    av_wdata = 32'h0;
    mode = erc_pkg::ERC_MODE_INIT;
    @(posedge clk);
    power_on();
    t_regs();
    t_alone();
    // Only a power-on reset may unlock the configuration
    power_on();
    t_share();
    print_verdict();
  end

  // Whole run needs under 400 cycles; 30000 cycles allows over seventy times that
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule : ext_regulator_config_ctrl_tb_top

bind erc_ctrl erc_ctrl_assertions u_chk (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .sys_mode_i(sys_mode_i),
  .base_above_upper_i(base_above_upper_i),
  .base_below_lower_i(base_below_lower_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .rail3_drive_en_o(rail3_drive_en_o),
  .current_limit_en_o(current_limit_en_o),
  .hp_regulator_en_o(hp_regulator_en_o),
  .lp_regulator_en_o(lp_regulator_en_o));
